/* File: bench/otpt_cell_model.sv */
// OTP cell model: measures strobe, gap, pulse and wake lengths.
// Assumes the macro side outputs of otpt_top on one clock.
module otpt_cell_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Macro side
  input  wire logic        cell_enable,
  input  wire logic        read_enable,
  input  wire logic        prog_pulse,
  input  wire logic [63:0] prog_word,
  // Measurements
  output logic      [15:0] re_len,
  output logic      [15:0] re_gap,
  output logic      [15:0] pp_len,
  output logic      [15:0] wake_len,
  output logic      [63:0] word_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] re_c;
  logic [15:0] gap_c;
  logic [15:0] pp_c;
  logic [15:0] wk_c;
  logic        re_q;
  logic        pp_q;
  logic        woke;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {re_c, gap_c, pp_c, wk_c, re_q, pp_q, woke} <= '0;
      {re_len, re_gap, pp_len, wake_len, word_seen} <= '0;
    end
    else
    begin
      re_q <= read_enable;
      pp_q <= prog_pulse;
      re_c <= read_enable ? re_c + 16'h1 : 16'h0;
      gap_c <= read_enable ? 16'h0 : gap_c + 16'h1;
      pp_c <= prog_pulse ? pp_c + 16'h1 : 16'h0;
      if (re_q && !read_enable)
        re_len <= re_c;
      if (!re_q && read_enable)
        re_gap <= gap_c;
      if (pp_q && !prog_pulse)
        pp_len <= pp_c;
      if (!pp_q && prog_pulse)
        word_seen <= prog_word;
      if (read_enable && !woke)
        wake_len <= wk_c;
      if (!cell_enable)
      begin
        wk_c <= 16'h0;
        woke <= 1'b0;
      end
      else if (read_enable)
        woke <= 1'b1;
      else if (!woke)
        wk_c <= wk_c + 16'h1;
    end
  end
endmodule : otpt_cell_model

/* File: bench/tb.sv */
// Testbench of otpt_top: APB register tests and cell sequence timing.
// Assumes otpt_defines.svh on the include path and the cell model.
`include "otpt_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, psel, penable, pwrite, rd_req;
  logic [31:0] paddr, pwdata, prdata, rdata;
  logic        pready, pslverr, rerr, rd_ready, rd_ack;
  logic        cell_enable, read_enable, prog_pulse, prog_done;
  logic [63:0] prog_word, word_seen;
  logic [15:0] re_len, re_gap, pp_len, wake_len;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  otpt_top dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rd_req(rd_req), .rd_ready(rd_ready), .rd_ack(rd_ack),
    .cell_enable(cell_enable), .read_enable(read_enable), .prog_pulse(prog_pulse),
    .prog_done(prog_done), .prog_word(prog_word));
  otpt_cell_model u_cell (.clk(ref_clk), .rst(rst), .cell_enable(cell_enable),
    .read_enable(read_enable), .prog_pulse(prog_pulse), .prog_word(prog_word),
    .re_len(re_len), .re_gap(re_gap), .pp_len(pp_len), .wake_len(wake_len),
    .word_seen(word_seen));
  // ****************************************
  // Tasks
  // ****************************************
  task report_and_stop;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rdata, exp);
  endtask : rdchk
  // Holds the request for n takes, then waits for the last strobe end
  task rd(input int n);
    int k;
    k = 0;
    @(posedge ref_clk);
    rd_req <= 1'b1;
    while (k < n)
    begin
      @(posedge ref_clk);
      if (rd_ready === 1'b1)
        k++;
    end
    rd_req <= 1'b0;
    do @(posedge ref_clk); while (rd_ack !== 1'b1);
    @(posedge ref_clk);
  endtask : rd
  function automatic logic [31:0] tim1(input logic t25);
    return {t25, 4'h3, 5'h8, 6'h10, 8'h05, 8'h04};
  endfunction : tim1
  function automatic logic [31:0] tim2(input logic g, input logic [6:0] b,
                                       input logic [9:0] thr);
    return {8'h00, g, b, 6'h00, thr};
  endfunction : tim2
  // ****************************************
  // Clock, reset and timeout
  // ****************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      report_and_stop;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst, psel, penable, pwrite, rd_req} = 5'b10000;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk("word_lo_rst", `OTPT_ADDR_WORD_LO, 32'h0);
    rdchk("word_hi_rst", `OTPT_ADDR_WORD_HI, 32'h0);
    rdchk("tim1_rst", `OTPT_ADDR_TIM_ONE, 32'h1a10_4f20);
    rdchk("tim2_rst", `OTPT_ADDR_TIM_TWO, tim2(1'b0, 7'h01, 10'h0));
    apb(1'b1, `OTPT_ADDR_WORD_LO, 32'ha5a5_1234);
    apb(1'b1, `OTPT_ADDR_WORD_HI, 32'h0f1e_2d3c);
    rdchk("word_lo", `OTPT_ADDR_WORD_LO, 32'ha5a5_1234);
    rdchk("word_hi", `OTPT_ADDR_WORD_HI, 32'h0f1e_2d3c);
    chk("prog_word", prog_word, 64'h0f1e_2d3c_a5a5_1234);
    apb(1'b1, `OTPT_ADDR_TIM_TWO, 32'hffff_ffff);
    rdchk("tim2_fields", `OTPT_ADDR_TIM_TWO, 32'h00ff_03ff);
    rdchk("unmapped_data", 32'h07f4_0030, 32'h0);
    chk("unmapped_err", rerr, 64'h1);
    apb(1'b1, `OTPT_ADDR_TIM_TWO, tim2(1'b0, 7'h01, 10'h0));
    apb(1'b1, `OTPT_ADDR_TIM_ONE, tim1(1'b0));
    apb(1'b1, `OTPT_ADDR_MODE, 32'h0000_0012);
    do @(posedge ref_clk); while (prog_done !== 1'b1);
    @(posedge ref_clk);
    chk("pulse_len", pp_len, 64'h6);
    chk("done_pulse", prog_done, 64'h0);
    chk("word_seen", word_seen, 64'h0f1e_2d3c_a5a5_1234);
    apb(1'b1, `OTPT_ADDR_MODE, 32'h0000_0001);
    while (rd_ready !== 1'b1) @(posedge ref_clk);
    rd(2);
    chk("strobe_t25_0", re_len, 64'h1);
    chk("gap_plain", re_gap, 64'h1);
    apb(1'b1, `OTPT_ADDR_TIM_ONE, tim1(1'b1));
    apb(1'b1, `OTPT_ADDR_TIM_TWO, tim2(1'b1, 7'h01, 10'h0));
    rd(2);
    chk("strobe_t25_1", re_len, 64'h2);
    chk("gap_guard", re_gap, 64'h2);
    apb(1'b1, `OTPT_ADDR_TIM_ONE, tim1(1'b0));
    rd(2);
    chk("gap_guard_t25_0", re_gap, 64'h1);
    apb(1'b1, `OTPT_ADDR_TIM_ONE, tim1(1'b1));
    apb(1'b1, `OTPT_ADDR_TIM_TWO, tim2(1'b0, 7'h01, 10'h005));
    rd(2);
    chk("gap_noguard", re_gap, 64'h1);
    repeat (30) @(posedge ref_clk);
    chk("standby", cell_enable, 64'h0);
    rd(1);
    chk("wake_len", wake_len, 64'h6);
    apb(1'b1, `OTPT_ADDR_TIM_TWO, tim2(1'b0, 7'h01, 10'h0));
    rd(1);
    repeat (40) @(posedge ref_clk);
    chk("no_standby", cell_enable, 64'h1);
    apb(1'b1, `OTPT_ADDR_TIM_TWO, tim2(1'b0, 7'h03, 10'h0));
    apb(1'b1, `OTPT_ADDR_MODE, 32'h0000_0005);
    while (rd_ready !== 1'b1) @(posedge ref_clk);
    rd(1);
    chk("blank_strobe", re_len, 64'h4);
    report_and_stop;
  end
endmodule : tb

/* File: design/otpt_cnt_if.sv */
// Start, load value and hit of one cycle counter.
// Assumes one clock and an active high asynchronous reset.
interface otpt_cnt_if #(parameter int W = 8) (
  input wire logic clk,
  input wire logic rst
);
  logic         start;
  logic [W-1:0] value;
  logic         hit;
  modport owner   (output start, output value, input hit);
  modport counter (input clk, input rst, input start, input value, output hit);
endinterface : otpt_cnt_if

/* File: design/otpt_defines.svh */
// Constants of the OTP timing and program word block.
// Assumes inclusion by bare name from the package, the top module and the testbench.
`ifndef OTPT_DEFINES_SVH
`define OTPT_DEFINES_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define OTPT_ADDR_WORD_LO  32'h07f4_0020
`define OTPT_ADDR_WORD_HI  32'h07f4_0024
`define OTPT_ADDR_TIM_ONE  32'h07f4_0028
`define OTPT_ADDR_TIM_TWO  32'h07f4_002c
`define OTPT_ADDR_MODE     32'h07f4_0040
`define OTPT_ADDR_STATUS   32'h07f4_0044
// ****************************************
// Field positions
// ****************************************
`define OTPT_T25_BIT       31
`define OTPT_T200_RANGE    30:27
`define OTPT_T500_RANGE    26:22
`define OTPT_T1US_RANGE    21:16
`define OTPT_PW_RANGE      15:8
`define OTPT_CADX_RANGE    7:0
`define OTPT_GUARD_BIT     23
`define OTPT_BCHK_RANGE    22:16
`define OTPT_STBY_RANGE    9:0
`define OTPT_MODE_RANGE    2:0
`define OTPT_PROG_GO_BIT   4
// ****************************************
// Reset values
// ****************************************
`define OTPT_WORD_RST      32'h0000_0000
`define OTPT_T25_RST       1'h0
`define OTPT_T200_RST      4'h3
`define OTPT_T500_RST      5'h8
`define OTPT_T1US_RST      6'h10
`define OTPT_PW_RST        8'h4f
`define OTPT_CADX_RST      8'h20
`define OTPT_GUARD_RST     1'h0
`define OTPT_BCHK_RST      7'h01
`define OTPT_STBY_RST      10'h000
`define OTPT_RDATA_ZERO    32'h0000_0000
// ****************************************
// Mode codes and fixed counts
// ****************************************
`define OTPT_MODE_STBY     3'h0
`define OTPT_MODE_MANUAL_READ_MODE    3'h1
`define OTPT_MODE_MANUAL_PROGRAM_MODE    3'h2
`define OTPT_MODE_BLANK_TEST_MODE   3'h5
`define OTPT_GAP_EXTRA     8'h00
`endif

/* File: design/otpt_idle_watch.sv */
// Idle watch: hit once more than value cycles pass without start; never hits while value is zero.
// Assumes start is high whenever idle time must not accumulate.
module otpt_idle_watch (
  // Counter port
  otpt_cnt_if.counter tif
);
  localparam int W = $bits(tif.value);
  logic [W:0] idle;

  // Saturates one above the threshold
  always_ff @(posedge tif.clk or posedge tif.rst)
  begin
    if (tif.rst)
      idle <= '0;
    else if (tif.start)
      idle <= '0;
    else if (idle <= {1'b0, tif.value})
      idle <= idle + 1'b1;
  end

  assign tif.hit = (tif.value != '0) && (idle > {1'b0, tif.value});
endmodule : otpt_idle_watch

/* File: design/otpt_interval.sv */
// Down counter: after start, hit rises in cycle value+1.
// Assumes start is a one-cycle pulse from the owner.
module otpt_interval (
  // Counter port
  otpt_cnt_if.counter tif
);
  logic [$bits(tif.value)-1:0] cnt;
  logic                        busy;

  always_ff @(posedge tif.clk or posedge tif.rst)
  begin
    if (tif.rst)
    begin
      cnt  <= '0;
      busy <= 1'b0;
    end
    else if (tif.start)
    begin
      cnt  <= tif.value;
      busy <= 1'b1;
    end
    else if (busy)
    begin
      if (cnt == '0)
        busy <= 1'b0;
      else
        cnt <= cnt - 1'b1;
    end
  end

  assign tif.hit = busy && (cnt == '0);
endmodule : otpt_interval

/* File: design/otpt_pkg.sv */
// Types of the OTP timing and program word block.
// Assumes otpt_defines.svh is on the include path.
`include "otpt_defines.svh"
package otpt_pkg;
  typedef enum logic [2:0] {
    OTPT_STANDBY = `OTPT_MODE_STBY,
    OTPT_MANUAL_READ_MODE   = `OTPT_MODE_MANUAL_READ_MODE,
    OTPT_MANUAL_PROGRAM_MODE   = `OTPT_MODE_MANUAL_PROGRAM_MODE,
    OTPT_BLANK_TEST_MODE  = `OTPT_MODE_BLANK_TEST_MODE
  } otpt_mode_t;
  // Gray along off, wake, active, read, gap
  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_WAKE   = 3'h1,
    ST_ACTIVE = 3'h3,
    ST_READ   = 3'h2,
    ST_GAP    = 3'h6,
    ST_PROG   = 3'h7,
    ST_STBY   = 3'h5
  } otpt_state_t;
endpackage : otpt_pkg

/* File: design/otpt_top.sv */
// OTP timing and program word block: APB registers and cell sequencer.
// Assumes APB master on ref_clk, OTP macro and read requester synchronous.
//
// Summary of operation
// [RQ1] Low program word register, 32 bits
// [RQ2] High program word register, 32 bits
// [RQ3] 25 ns count bit 31, reset 0
// [RQ4] 200 ns count bits 30:27, reset 3
// [RQ5] 500 ns count bits 26:22, reset 8
// [RQ6] 1 us count bits 21:16, reset 0x10
// [RQ7] Program pulse count bits 15:8, reset 0x4f
// [RQ8] Cell enable wait bits 7:0, reset 0x20
// [RQ9] Guard plus 25 ns: two-cycle read gap
// [RQ10] Guard ignored when 25 ns count zero
// [RQ11] Blank read count bits 22:16, reset 1
// [RQ12] Idle beyond threshold puts cell in standby; done in manual read mode only
// [RQ13] Read after standby waits cell enable time
// [RQ14] Zero threshold disables standby saving
// [RQ15] Blank test selected by mode 0x5
// [RQ16] Intervals last field value plus one cycles
//
// Local design decision: register access over APB.
`include "otpt_defines.svh"
module otpt_top
  import otpt_pkg::*;
#(
  parameter int SEQ_W  = 8,
  parameter int IDLE_W = 10
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Read requests
  input  wire logic        rd_req,
  output logic             rd_ready,
  output logic             rd_ack,
  // OTP macro
  output logic             cell_enable,
  output logic             read_enable,
  output logic             prog_pulse,
  output logic             prog_done,
  output logic      [63:0] prog_word
);
  // ****************************************
  // Parameter checks
  // ****************************************
  if (SEQ_W < 8)
    $error("otpt_top: SEQ_W must be at least 8");
  if (IDLE_W != 10)
    $error("otpt_top: IDLE_W must be 10");

  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0]      prog_word_lower_half;
  logic [31:0]      prog_word_upper_half;
  logic             interval_25ns_count;
  logic [3:0]       interval_200ns_count;
  logic [4:0]       interval_500ns_count;
  logic [5:0]       interval_1us_count;
  logic [7:0]       program_pulse_count;
  logic [7:0]       cell_enable_wait_count;
  logic             read_enable_gap_guard;
  logic [6:0]       blank_check_read_count;
  logic [9:0]       idle_standby_threshold;
  otpt_mode_t       controller_mode_field;
  logic             prog_go;
  logic             pend_read;
  otpt_state_t      state;
  otpt_state_t      next_state;
  logic             next_start;
  logic [SEQ_W-1:0] next_load;
  logic [SEQ_W-1:0] read_len;
  logic             bus_wr;
  logic             bus_setup;
  logic [31:0]      rd_word;
  logic             rd_hit;
  logic             read_mode;
  logic             cell_mode;
  logic             gap_on;
  logic             rd_take;
  logic             prog_take;

  otpt_cnt_if #(.W(SEQ_W))  seq_if  (.clk(ref_clk), .rst(rst));
  otpt_cnt_if #(.W(IDLE_W)) idle_if (.clk(ref_clk), .rst(rst));

  otpt_interval u_seq_timer (
    .tif (seq_if)
  );

  otpt_idle_watch u_idle_watch (
    .tif (idle_if)
  );

  // ****************************************
  // APB slave
  // ****************************************
  assign bus_setup = psel && !penable;
  assign bus_wr    = psel && penable && pwrite && pready;

  always_comb
  begin
    rd_word = `OTPT_RDATA_ZERO;
    rd_hit  = 1'b1;
    if (paddr == `OTPT_ADDR_WORD_LO)
      rd_word = prog_word_lower_half;
    else if (paddr == `OTPT_ADDR_WORD_HI)
      rd_word = prog_word_upper_half;
    else if (paddr == `OTPT_ADDR_TIM_ONE)
      rd_word = {interval_25ns_count, interval_200ns_count, interval_500ns_count,
                 interval_1us_count, program_pulse_count, cell_enable_wait_count};
    else if (paddr == `OTPT_ADDR_TIM_TWO)
      rd_word = {8'h00, read_enable_gap_guard, blank_check_read_count, 6'h00,
                 idle_standby_threshold};
    else if (paddr == `OTPT_ADDR_MODE)
      rd_word = {27'h0, prog_go, 1'b0, controller_mode_field};
    else if (paddr == `OTPT_ADDR_STATUS)
      rd_word = {26'h0, pend_read, idle_if.hit, cell_enable, state};
    else
      rd_hit = 1'b0;
  end

  // No wait state: answer in the first access cycle after setup
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `OTPT_RDATA_ZERO;
    end
    else
    begin
      pready  <= bus_setup;
      pslverr <= bus_setup && !rd_hit;
      if (bus_setup)
        prdata <= pwrite ? `OTPT_RDATA_ZERO : rd_word;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // [RQ1] [RQ2] Program word staging
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prog_word_lower_half <= `OTPT_WORD_RST;
      prog_word_upper_half <= `OTPT_WORD_RST;
    end
    else if (bus_wr && paddr == `OTPT_ADDR_WORD_LO)
      prog_word_lower_half <= pwdata;
    else if (bus_wr && paddr == `OTPT_ADDR_WORD_HI)
      prog_word_upper_half <= pwdata;
  end

  assign prog_word = {prog_word_upper_half, prog_word_lower_half};

  // [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] Timing one fields
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      interval_25ns_count    <= `OTPT_T25_RST;
      interval_200ns_count   <= `OTPT_T200_RST;
      interval_500ns_count   <= `OTPT_T500_RST;
      interval_1us_count     <= `OTPT_T1US_RST;
      program_pulse_count    <= `OTPT_PW_RST;
      cell_enable_wait_count <= `OTPT_CADX_RST;
    end
    else if (bus_wr && paddr == `OTPT_ADDR_TIM_ONE)
    begin
      interval_25ns_count    <= pwdata[`OTPT_T25_BIT];
      interval_200ns_count   <= pwdata[`OTPT_T200_RANGE];
      interval_500ns_count   <= pwdata[`OTPT_T500_RANGE];
      interval_1us_count     <= pwdata[`OTPT_T1US_RANGE];
      program_pulse_count    <= pwdata[`OTPT_PW_RANGE];
      cell_enable_wait_count <= pwdata[`OTPT_CADX_RANGE];
    end
  end

  // [RQ11] Timing two fields, reserved bits not stored
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      read_enable_gap_guard  <= `OTPT_GUARD_RST;
      blank_check_read_count <= `OTPT_BCHK_RST;
      idle_standby_threshold <= `OTPT_STBY_RST;
    end
    else if (bus_wr && paddr == `OTPT_ADDR_TIM_TWO)
    begin
      read_enable_gap_guard  <= pwdata[`OTPT_GUARD_BIT];
      blank_check_read_count <= pwdata[`OTPT_BCHK_RANGE];
      idle_standby_threshold <= pwdata[`OTPT_STBY_RANGE];
    end
  end

  // Mode select; program trigger set wins over its clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      controller_mode_field <= OTPT_STANDBY;
      prog_go               <= 1'b0;
    end
    else
    begin
      if (bus_wr && paddr == `OTPT_ADDR_MODE)
        controller_mode_field <= otpt_mode_t'(pwdata[`OTPT_MODE_RANGE]);
      if (bus_wr && paddr == `OTPT_ADDR_MODE && pwdata[`OTPT_PROG_GO_BIT])
        prog_go <= 1'b1;
      else if (prog_take)
        prog_go <= 1'b0;
    end
  end

  // ****************************************
  // Cell sequencer
  // ****************************************
  // [RQ15] Blank test selected by its mode code
  assign read_mode = controller_mode_field == OTPT_MANUAL_READ_MODE ||
                     controller_mode_field == OTPT_BLANK_TEST_MODE;
  assign cell_mode = read_mode || controller_mode_field == OTPT_MANUAL_PROGRAM_MODE;
  // [RQ9] [RQ10] Gap only with guard and 25 ns count set
  assign gap_on    = read_enable_gap_guard && interval_25ns_count;
  assign rd_take   = rd_req && rd_ready;
  assign prog_take = state == ST_ACTIVE && next_state == ST_PROG;
  // [RQ11] Blank test reads use the blank check count
  assign read_len  = (controller_mode_field == OTPT_BLANK_TEST_MODE) ?
                     SEQ_W'(blank_check_read_count) : SEQ_W'(interval_25ns_count);

  always_comb
  begin
    next_state = state;
    next_start = 1'b0;
    next_load  = '0;
    case (state)
      ST_OFF:
        if (cell_mode)
        begin
          next_state = ST_WAKE;
          next_start = 1'b1;
          next_load  = SEQ_W'(cell_enable_wait_count);
        end
      ST_WAKE:
        if (!cell_mode)
          next_state = ST_OFF;
        else if (seq_if.hit)
          next_state = ST_ACTIVE;
      ST_ACTIVE:
        if (!cell_mode)
          next_state = ST_OFF;
        else if (read_mode && (rd_take || pend_read))
        begin
          next_state = ST_READ;
          next_start = 1'b1;
          next_load  = read_len;
        end
        else if (controller_mode_field == OTPT_MANUAL_PROGRAM_MODE && prog_go)
        begin
          next_state = ST_PROG;
          next_start = 1'b1;
          next_load  = SEQ_W'(program_pulse_count);
        end
        // [RQ12] [RQ14] Idle standby in manual read only
        else if (controller_mode_field == OTPT_MANUAL_READ_MODE && idle_if.hit)
          next_state = ST_STBY;
      ST_READ:
        if (seq_if.hit)
        begin
          if (gap_on)
          begin
            next_state = ST_GAP;
            next_start = 1'b1;
            next_load  = SEQ_W'(`OTPT_GAP_EXTRA);
          end
          else
            next_state = ST_ACTIVE;
        end
      ST_GAP, ST_PROG:
        if (seq_if.hit)
          next_state = ST_ACTIVE;
      ST_STBY:
        if (controller_mode_field != OTPT_MANUAL_READ_MODE)
          next_state = ST_OFF;
        // [RQ13] Wake the cell and wait before reading
        else if (rd_take)
        begin
          next_state = ST_WAKE;
          next_start = 1'b1;
          next_load  = SEQ_W'(cell_enable_wait_count);
        end
      default:
        next_state = ST_OFF;
    endcase
  end

  // [RQ16] Every timed step runs value plus one cycles
  assign seq_if.start = next_start;
  assign seq_if.value = next_load;

  // [RQ12] Idle time counts only while active in manual read
  assign idle_if.start = !(state == ST_ACTIVE && controller_mode_field == OTPT_MANUAL_READ_MODE) ||
                         rd_take;
  assign idle_if.value = idle_standby_threshold;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  // Request taken while the cell sleeps waits for wake
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pend_read <= 1'b0;
    else if (rd_take && next_state != ST_READ)
      pend_read <= 1'b1;
    else if (next_state == ST_READ || state == ST_OFF)
      pend_read <= 1'b0;
  end

  // ****************************************
  // Macro and requester outputs
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cell_enable <= 1'b0;
      read_enable <= 1'b0;
      prog_pulse  <= 1'b0;
      prog_done   <= 1'b0;
      rd_ack      <= 1'b0;
      rd_ready    <= 1'b0;
    end
    else
    begin
      cell_enable <= next_state != ST_OFF && next_state != ST_STBY;
      read_enable <= next_state == ST_READ;
      // [RQ7] Pulse lasts program pulse count plus one
      prog_pulse  <= next_state == ST_PROG;
      prog_done   <= state == ST_PROG && next_state != ST_PROG;
      rd_ack      <= state == ST_READ && next_state != ST_READ;
      // [RQ9] Ready withheld during the gap: extra wait state
      rd_ready    <= read_mode && !pend_read && !rd_take &&
                     (next_state == ST_ACTIVE || next_state == ST_STBY);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [SEQ_W:0] seq_len;
  logic [SEQ_W:0] exp_len;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      seq_len <= '0;
      exp_len <= '0;
    end
    else
    begin
      seq_len <= (next_state != state) ? (SEQ_W + 1)'(1) : seq_len + 1'b1;
      if (next_start)
        exp_len <= {1'b0, next_load} + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_word_low:   assert property (bus_wr && paddr == `OTPT_ADDR_WORD_LO |=> // [RQ1]
                  prog_word[31:0] == $past(pwdata))
    else $error("low program word not stored");
  a_word_high:  assert property (bus_wr && paddr == `OTPT_ADDR_WORD_HI |=> // [RQ2]
                  prog_word[63:32] == $past(pwdata))
    else $error("high program word not stored");
  a_timing_one: assert property (bus_wr && paddr == `OTPT_ADDR_TIM_ONE |=> // [RQ3]
                  {interval_25ns_count, interval_200ns_count, interval_500ns_count,
                   interval_1us_count} == $past(pwdata[31:16]))
    else $error("timing one fields not stored");
  a_read_len:   assert property ($fell(read_enable) |-> // [RQ16]
                  $past(seq_len) == $past(exp_len))
    else $error("read strobe length wrong");
  a_blank_len:  assert property ($rose(read_enable) && controller_mode_field == OTPT_BLANK_TEST_MODE
                  |-> exp_len == blank_check_read_count + 1'b1) // [RQ11]
    else $error("blank read length wrong");
  a_pulse_len:  assert property ($fell(prog_pulse) |-> // [RQ7]
                  $past(seq_len) == program_pulse_count + 1'b1)
    else $error("program pulse length wrong");
  a_wake_wait:  assert property (state == ST_WAKE && next_state == ST_ACTIVE |-> // [RQ8]
                  seq_len == cell_enable_wait_count + 1'b1)
    else $error("cell enable wait wrong");
  a_gap_two:    assert property ($fell(read_enable) && gap_on |-> // [RQ9]
                  !read_enable [*2])
    else $error("read gap shorter than two cycles");
  a_gap_one:    assert property ($fell(read_enable) && !interval_25ns_count |-> // [RQ10]
                  !read_enable && state != ST_GAP)
    else $error("guard acted with zero 25 ns count");
  a_stby_enter: assert property (state == ST_STBY |-> // [RQ12]
                  !cell_enable && $past(controller_mode_field) == OTPT_MANUAL_READ_MODE)
    else $error("standby outside manual read");
  a_stby_off:   assert property (idle_standby_threshold == '0 |-> // [RQ14]
                  next_state != ST_STBY)
    else $error("standby with zero threshold");
  a_wake_read:  assert property (state == ST_STBY && rd_take && // [RQ13]
                  controller_mode_field == OTPT_MANUAL_READ_MODE |=>
                  state == ST_WAKE && cell_enable && !read_enable)
    else $error("read after standby did not wake");
  a_blank_mode: assert property (state == ST_READ && exp_len != interval_25ns_count + 1'b1
                  |-> controller_mode_field == OTPT_BLANK_TEST_MODE) // [RQ15]
    else $error("blank count used outside blank test");

  c_guard_read: cover property ($fell(read_enable) && gap_on ##2 $rose(read_enable));
  c_stby_wake:  cover property (state == ST_STBY ##1 state == ST_WAKE);
  c_prog_pulse: cover property ($fell(prog_pulse) ##0 prog_done);
  c_blank_read: cover property ($rose(read_enable) && controller_mode_field == OTPT_BLANK_TEST_MODE);
endmodule : otpt_top
